//--- hw/curve_point_mem.sv
// small register memory for curve points, registered read port
module curve_point_mem
  import scaling_curve_pkg::*;
(
  // clock and enable
  input wire logic clk_i,
  input wire logic ce_i,
  // write port
  input wire logic we_i,
  input wire logic [`SC_PT_W-1:0] waddr_i,
  input wire scaling_curve_pkg::point_s wdata_i,
  // read port
  input wire logic [`SC_PT_W-1:0] raddr_i,
  output scaling_curve_pkg::point_s rdata_o
);
  point_s mem_r [`SC_NPTS];
  // no reset on storage; software loads points before enabling points
  always_ff @(posedge clk_i)
  begin
    if (ce_i)
    begin
      if (we_i)
        mem_r[waddr_i] <= wdata_i;
      rdata_o <= mem_r[raddr_i];
    end
  end
endmodule

//--- hw/scaling_curve_unit.sv
// analog input scaling curve: select, filter, range check, interpolate, round
`include "scaling_curve_params.svh"
module scaling_curve_unit
  import scaling_curve_pkg::*;
(
  // clock, reset, enable
  input wire logic CLK_I,
  input wire logic RESET_I,
  input wire logic CE_I,
  // measurements, all on CLK_I, and their valid levels
  input wire scaling_curve_pkg::fix_t MEAS_I [1<<`SC_SRC_W],
  input wire logic [(1<<`SC_SRC_W)-1:0] MEAS_VALID_I,
  // configuration
  input wire scaling_curve_pkg::cfg_s CFG_I,
  // curve point load and enables
  input wire logic PT_WE_I,
  input wire logic [`SC_PT_W-1:0] PT_ADDR_I,
  input wire scaling_curve_pkg::point_s PT_DATA_I,
  input wire logic [`SC_NPTS-1:0] PT_EN_I,
  // indications
  output scaling_curve_pkg::fix_t CURVE_IN_O,
  output scaling_curve_pkg::fix_t CURVE_OUT_O,
  output logic OUT_OF_RANGE_O,
  output logic RESULT_VALID_O
);
  typedef enum logic [2:0] {S_IDLE, S_SEARCH, S_WAIT, S_CALC, S_DIV, S_ROUND} state_e;

  state_e state_r, state_nxt;
  logic [31:0] tick_cnt_r, tick_cnt_nxt;
  logic [10:0] step_cnt_r, step_cnt_nxt;
  fix_t held_r, held_nxt;
  fix_t filt_r, filt_nxt;
  fix_t curve_in_r, curve_in_nxt;
  fix_t curve_out_r, curve_out_nxt;
  // working result, so the visible output only moves together with the valid pulse
  fix_t acc_r, acc_nxt;
  logic oor_r, oor_nxt;
  logic valid_r, valid_nxt;
  logic [`SC_PT_W-1:0] idx_r, idx_nxt;
  logic [`SC_PT_W-1:0] raddr;
  point_s rd_pt;
  point_s lo_r, lo_nxt;
  logic have_lo_r, have_lo_nxt;
  logic signed [2*`SC_DW-1:0] num_r, num_nxt;
  fix_t den_r, den_nxt;
  fix_t quo_r, quo_nxt;
  logic [6:0] bit_r, bit_nxt;
  logic neg_r, neg_nxt;
  logic active;
  logic upd_tick;
  fix_t sel_meas;
  logic sel_valid;
  logic [`SC_NPTS-1:0] pt_en_eff;
  logic signed [2*`SC_DW-1:0] rem_try;
  logic [`SC_DW-1:0] frac_mask;

  // two default points share storage with the loaded points
  assign pt_en_eff = PT_EN_I | `SC_PTEN_DEFAULT;
  assign active = CFG_I.global_en & CFG_I.curve_en;
  assign sel_meas = MEAS_I[CFG_I.src_sel];
  assign sel_valid = MEAS_VALID_I[CFG_I.src_sel];
  assign upd_tick = (step_cnt_r >= CFG_I.upd_cycle) && (tick_cnt_r == 32'h0);
  assign raddr = idx_r;
  assign frac_mask = (`SC_DW)'(`SC_ONE) - (`SC_DW)'(1);
  assign rem_try = num_r - ((2*`SC_DW)'(den_r) <<< bit_r);

  curve_point_mem u_mem (
    .clk_i(CLK_I),
    .ce_i(CE_I),
    .we_i(PT_WE_I),
    .waddr_i(PT_ADDR_I),
    .wdata_i(PT_DATA_I),
    .raddr_i(raddr),
    .rdata_o(rd_pt)
  );

  // next state of the whole pipeline; one comb and one ff block
  always_comb
  begin
    state_nxt = state_r;
    tick_cnt_nxt = tick_cnt_r;
    step_cnt_nxt = step_cnt_r;
    held_nxt = held_r;
    filt_nxt = filt_r;
    curve_in_nxt = curve_in_r;
    curve_out_nxt = curve_out_r;
    acc_nxt = acc_r;
    oor_nxt = oor_r;
    valid_nxt = 1'b0;
    idx_nxt = idx_r;
    lo_nxt = lo_r;
    have_lo_nxt = have_lo_r;
    num_nxt = num_r;
    den_nxt = den_r;
    quo_nxt = quo_r;
    bit_nxt = bit_r;
    neg_nxt = neg_r;
    // 5 ms prescaler shared by the update cycle
    if (tick_cnt_r == 32'(`SC_UPD_STEP_CYC - 1))
    begin
      tick_cnt_nxt = 32'h0;
      step_cnt_nxt = step_cnt_r + 11'h001;
    end
    else
      tick_cnt_nxt = tick_cnt_r + 32'h1;
    // keeping the last good sample covers signal loss
    if (sel_valid)
      held_nxt = sel_meas;
    // filter runs every 5 ms step; alpha = step/tc via a shifted divide by filt_tc
    if (tick_cnt_r == 32'h0)
    begin
      if (CFG_I.filt_en && CFG_I.filt_tc != 16'h0)
        // unity DC gain: filt += (x - filt) * 1 / tc_steps
        filt_nxt = filt_r + fix_t'(((held_r - filt_r) <<< `SC_FILT_SHIFT) / $signed({1'b0, CFG_I.filt_tc}) >>> `SC_FILT_SHIFT);
      else
        filt_nxt = held_r;
    end
    case (state_r)
      S_IDLE:
      begin
        if (active && upd_tick)
        begin
          // restart at zero so a setting of n waits n full steps
          step_cnt_nxt = 11'h000;
          curve_in_nxt = CFG_I.filt_en ? filt_r : held_r;
          // limits only watched with supervision on
          oor_nxt = CFG_I.range_en && (((CFG_I.filt_en ? filt_r : held_r) < CFG_I.in_min) ||
                    ((CFG_I.filt_en ? filt_r : held_r) > CFG_I.in_max));
          idx_nxt = '0;
          have_lo_nxt = 1'b0;
          state_nxt = S_WAIT;
        end
        else if (!active)
          oor_nxt = 1'b0;
      end
      S_WAIT:
        state_nxt = S_SEARCH; // memory read latency
      S_SEARCH:
      begin
        // walk enabled points in order, stop at first point after the first enabled one that is at or above the input
        if (pt_en_eff[idx_r] && have_lo_r && rd_pt.in_val >= curve_in_r)
          state_nxt = S_CALC;
        else
        begin
          if (pt_en_eff[idx_r])
          begin
            lo_nxt = rd_pt;
            have_lo_nxt = 1'b1;
          end
          if (idx_r == 5'(`SC_NPTS - 1))
          begin
            // input beyond last point: hold last point output
            acc_nxt = pt_en_eff[idx_r] ? rd_pt.out_val : lo_r.out_val;
            state_nxt = S_ROUND;
          end
          else
          begin
            idx_nxt = idx_r + 5'h01;
            state_nxt = S_WAIT;
          end
        end
      end
      S_CALC:
      begin
        // below the first point clamps to its output
        if (curve_in_r <= lo_r.in_val || rd_pt.in_val == lo_r.in_val)
        begin
          acc_nxt = lo_r.out_val;
          state_nxt = S_ROUND;
        end
        else
        begin
          num_nxt = (2*`SC_DW)'(rd_pt.out_val - lo_r.out_val) * (2*`SC_DW)'(curve_in_r - lo_r.in_val);
          neg_nxt = (rd_pt.out_val < lo_r.out_val);
          if (rd_pt.out_val < lo_r.out_val)
            num_nxt = -((2*`SC_DW)'(rd_pt.out_val - lo_r.out_val) * (2*`SC_DW)'(curve_in_r - lo_r.in_val));
          den_nxt = rd_pt.in_val - lo_r.in_val;
          quo_nxt = '0;
          bit_nxt = 7'(`SC_DW - 2);
          state_nxt = S_DIV;
        end
      end
      S_DIV:
      begin
        // restoring division, one quotient bit a cycle to keep timing short
        if (rem_try >= 0)
        begin
          num_nxt = rem_try;
          quo_nxt = quo_r | (fix_t'(1) <<< bit_r);
        end
        if (bit_r == 7'h00)
        begin
          acc_nxt = lo_r.out_val + (neg_r ? -quo_nxt : quo_nxt);
          state_nxt = S_ROUND;
        end
        else
          bit_nxt = bit_r - 7'h01;
      end
      S_ROUND:
      begin
        case (CFG_I.rnd_mode)
          RND_FLOOR: curve_out_nxt = acc_r & ~fix_t'(frac_mask);
          RND_CEIL: curve_out_nxt = (acc_r + fix_t'(frac_mask)) & ~fix_t'(frac_mask);
          RND_NEAREST: curve_out_nxt = (acc_r + fix_t'(`SC_HALF)) & ~fix_t'(frac_mask);
          default: curve_out_nxt = acc_r;
        endcase
        valid_nxt = 1'b1;
        state_nxt = S_IDLE;
      end
      default:
        state_nxt = S_IDLE;
    endcase
  end

  // register stage; reset gives defaults of all control state
  always_ff @(posedge CLK_I)
  begin
    if (RESET_I)
    begin
      state_r <= S_IDLE;
      tick_cnt_r <= 32'h0;
      step_cnt_r <= 11'h000;
      held_r <= `SC_ZERO;
      filt_r <= `SC_ZERO;
      curve_in_r <= `SC_ZERO;
      curve_out_r <= `SC_ZERO;
      acc_r <= `SC_ZERO;
      oor_r <= 1'b0;
      valid_r <= 1'b0;
      idx_r <= '0;
      lo_r <= '0;
      have_lo_r <= 1'b0;
      num_r <= '0;
      den_r <= `SC_ZERO;
      quo_r <= `SC_ZERO;
      bit_r <= 7'h00;
      neg_r <= 1'b0;
    end
    else if (CE_I)
    begin
      state_r <= state_nxt;
      tick_cnt_r <= tick_cnt_nxt;
      step_cnt_r <= step_cnt_nxt;
      held_r <= held_nxt;
      filt_r <= filt_nxt;
      curve_in_r <= curve_in_nxt;
      curve_out_r <= curve_out_nxt;
      acc_r <= acc_nxt;
      oor_r <= oor_nxt;
      valid_r <= valid_nxt;
      idx_r <= idx_nxt;
      lo_r <= lo_nxt;
      have_lo_r <= have_lo_nxt;
      num_r <= num_nxt;
      den_r <= den_nxt;
      quo_r <= quo_nxt;
      bit_r <= bit_nxt;
      neg_r <= neg_nxt;
    end
  end

  // indications straight from registers
  assign CURVE_IN_O = curve_in_r;
  assign CURVE_OUT_O = curve_out_r;
  assign OUT_OF_RANGE_O = oor_r;
  assign RESULT_VALID_O = valid_r;
endmodule

//--- include/scaling_curve_params.svh
// timing, reset and layout constants for the scaling curve unit
`ifndef SCALING_CURVE_PARAMS_SVH
`define SCALING_CURVE_PARAMS_SVH
`define SC_CLK_HZ 40000000
`define SC_TC_STEP_US 5000
`define SC_TC_STEP_CYC ((`SC_CLK_HZ / 1000000) * `SC_TC_STEP_US)
`define SC_TC_DEFAULT 16'h00c8
`define SC_UPD_STEP_MS 5
`define SC_UPD_STEP_CYC ((`SC_CLK_HZ / 1000) * `SC_UPD_STEP_MS)
`define SC_UPD_DEFAULT 11'h01e
`define SC_NPTS 20
`define SC_PT_W 5
`define SC_DW 40
`define SC_FRAC 17
`define SC_SRC_W 6
`define SC_SRC_DEFAULT 6'h00
`define SC_ONE 40'h0000020000
`define SC_HALF 40'h0000010000
`define SC_ZERO 40'h0000000000
`define SC_PTEN_DEFAULT 20'h00003
`define SC_FILT_SHIFT 10
`endif

//--- include/scaling_curve_pkg.sv
// types shared by the scaling curve unit
package scaling_curve_pkg;
  `include "scaling_curve_params.svh"
  typedef logic signed [`SC_DW-1:0] fix_t;
  typedef enum logic [1:0] {RND_FLOAT, RND_FLOOR, RND_CEIL, RND_NEAREST} round_e;
  typedef struct packed {
    logic global_en;
    logic curve_en;
    logic [`SC_SRC_W-1:0] src_sel;
    logic filt_en;
    logic [15:0] filt_tc;
    logic range_en;
    fix_t in_min;
    fix_t in_max;
    logic [10:0] upd_cycle;
    round_e rnd_mode;
  } cfg_s;
  typedef struct packed {
    fix_t in_val;
    fix_t out_val;
  } point_s;
endpackage

//--- verification/meas_channels.sv
// model of the measurement channels feeding the unit
`include "scaling_curve_params.svh"
module meas_channels
  import scaling_curve_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // channel load
  input wire logic set_i,
  input wire logic [`SC_SRC_W-1:0] idx_i,
  input wire scaling_curve_pkg::fix_t val_i,
  input wire logic ok_i,
  // channel outputs
  output scaling_curve_pkg::fix_t meas_o [1<<`SC_SRC_W],
  output logic [(1<<`SC_SRC_W)-1:0] valid_o
);
  fix_t val_r [1<<`SC_SRC_W];
  // distinct values per channel so a wrong select shows
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      for (int i = 0; i < (1<<`SC_SRC_W); i++)
        val_r[i] <= fix_t'(i) <<< 20;
      valid_o <= '1;
    end
    else if (set_i)
    begin
      val_r[idx_i] <= val_i;
      valid_o[idx_i] <= ok_i;
    end
  end
  // a dead channel shows junk, so any holding must come from the unit
  always_comb
  begin
    for (int i = 0; i < (1<<`SC_SRC_W); i++)
      meas_o[i] = valid_o[i] ? val_r[i] : ~val_r[i];
  end
endmodule

//--- verification/scaling_curve_props.sv
// port-level assertions for the scaling curve unit
`include "scaling_curve_params.svh"
module scaling_curve_props
  import scaling_curve_pkg::*;
(
  // clock and reset
  input wire logic CLK_I,
  input wire logic RESET_I,
  // watched inputs
  input wire logic [(1<<`SC_SRC_W)-1:0] MEAS_VALID_I,
  input wire scaling_curve_pkg::cfg_s CFG_I,
  // watched outputs
  input wire scaling_curve_pkg::fix_t CURVE_IN_O,
  input wire scaling_curve_pkg::fix_t CURVE_OUT_O,
  input wire logic OUT_OF_RANGE_O,
  input wire logic RESULT_VALID_O
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (RESET_I);
  // result pulses are far apart, checked as 8 quiet cycles at the least
  sequence s_quiet;
    (!RESULT_VALID_O)[*8];
  endsequence
  // a fresh sample is answered within the compute budget
  sequence s_answer;
    ##[1:400] RESULT_VALID_O;
  endsequence
  chk_reset_clear: assert property ($fell(RESET_I) |-> CURVE_OUT_O == '0 && CURVE_IN_O == '0 && !RESULT_VALID_O)
    else $error("outputs not clear after reset");
  chk_valid_spacing: assert property (RESULT_VALID_O |=> s_quiet)
    else $error("result pulses too close");
  chk_disabled_quiet: assert property (!(CFG_I.global_en && CFG_I.curve_en) |=> !RESULT_VALID_O)
    else $error("result while disabled");
  chk_range_flag: assert property (RESULT_VALID_O && CFG_I.range_en |-> OUT_OF_RANGE_O ==
    ($signed(CURVE_IN_O) < $signed(CFG_I.in_min) || $signed(CURVE_IN_O) > $signed(CFG_I.in_max)))
    else $error("range flag wrong");
  chk_range_off: assert property (RESULT_VALID_O && !CFG_I.range_en |-> !OUT_OF_RANGE_O)
    else $error("range flag without enable");
  chk_out_changes: assert property (!$stable(CURVE_OUT_O) |-> RESULT_VALID_O)
    else $error("output moved without pulse");
  chk_in_answered: assert property ($changed(CURVE_IN_O) && CFG_I.curve_en && CFG_I.global_en |-> s_answer)
    else $error("sample not answered");
  chk_loss_hold: assert property ($changed(CURVE_IN_O) |-> MEAS_VALID_I[CFG_I.src_sel])
    else $error("input taken from lost channel");
endmodule

//--- verification/scaling_curve_unit_test.sv
// self-checking bench for the scaling curve unit
`include "scaling_curve_params.svh"
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin n_fail++; $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module scaling_curve_unit_test;
  timeunit 1ns;
  timeprecision 1ps;
  import scaling_curve_pkg::*;
  logic clk, rst, ce, pt_we, set, okv, oor, rvalid;
  fix_t meas [1<<`SC_SRC_W];
  logic [(1<<`SC_SRC_W)-1:0] mvalid;
  cfg_s cfg;
  logic [`SC_PT_W-1:0] pt_addr;
  logic [`SC_SRC_W-1:0] idx;
  point_s pt_data;
  logic [`SC_NPTS-1:0] pt_en;
  fix_t val, cin, cout;
  int n_fail = 0;
  int compares = 0;
  scaling_curve_unit scaling_curve_unit_inst (.CLK_I(clk), .RESET_I(rst), .CE_I(ce), .MEAS_I(meas),
    .MEAS_VALID_I(mvalid), .CFG_I(cfg), .PT_WE_I(pt_we), .PT_ADDR_I(pt_addr), .PT_DATA_I(pt_data),
    .PT_EN_I(pt_en), .CURVE_IN_O(cin), .CURVE_OUT_O(cout), .OUT_OF_RANGE_O(oor), .RESULT_VALID_O(rvalid));
  meas_channels meas_channels_inst (.clk_i(clk), .rst_i(rst), .set_i(set), .idx_i(idx), .val_i(val),
    .ok_i(okv), .meas_o(meas), .valid_o(mvalid));
  // clock at 40 MHz
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic end_sim();
    $display("compares %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // one point write, a single strobe cycle
  task automatic wr_pt(input logic [`SC_PT_W-1:0] a, input fix_t i, input fix_t o);
    @(posedge clk);
    pt_we <= 1'b1;
    pt_addr <= a;
    pt_data <= '{in_val: i, out_val: o};
    @(posedge clk);
    pt_we <= 1'b0;
  endtask
  // set channel 3 and the mode, then wait for the next result and compare
  task automatic step(input string nm, input round_e m, input fix_t v, input logic ok, input fix_t mx,
                      input fix_t e_in, input fix_t e_out, input logic e_oor);
    int n;
    @(posedge clk);
    cfg.rnd_mode <= m;
    cfg.in_max <= mx;
    set <= 1'b1;
    val <= v;
    okv <= ok;
    @(posedge clk);
    set <= 1'b0;
    n = 0;
    // the 5 ms prescaler is fixed, so each wait spans up to one step
    do
    begin
      @(posedge clk);
      #1;
      n++;
    end
    while (rvalid !== 1'b1 && n < 450000);
    if (n >= 450000)
    begin
      n_fail++;
      $display("[FAIL] %s no result", nm);
      end_sim();
    end
    else
    begin
      `CHK(nm, e_in, cin)
      `CHK(nm, e_out, cout)
      `CHK(nm, e_oor, oor)
      $display("test %s done", nm);
    end
  endtask
  initial
  begin
    rst = 1'b1;
    ce = 1'b1;
    cfg = '0;
    pt_we = 1'b0;
    pt_addr = '0;
    pt_data = '0;
    pt_en = 20'h00003;
    set = 1'b0;
    idx = 6'h03;
    val = '0;
    okv = 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    `CHK("reset out", 40'h0, cout)
    // line from (0,0) to (2.0,10.0)
    wr_pt(5'h00, 40'h0, 40'h0);
    wr_pt(5'h01, 40'h0000040000, 40'h0000140000);
    @(posedge clk);
    cfg.global_en <= 1'b1;
    cfg.curve_en <= 1'b1;
    cfg.src_sel <= 6'h03;
    cfg.range_en <= 1'b1;
    cfg.upd_cycle <= 11'h001;
    // 1 s time constant, well over twice any disturbance period in this bench
    cfg.filt_tc <= 16'h00c8;
    step("float", RND_FLOAT, 40'h20000, 1'b1, 40'h10000, 40'h20000, 40'ha0000, 1'b1);
    step("floor", RND_FLOOR, 40'h0c000, 1'b1, 40'h40000, 40'h0c000, 40'h20000, 1'b0);
    step("ceil", RND_CEIL, 40'h0c000, 1'b1, 40'h40000, 40'h0c000, 40'h40000, 1'b0);
    step("nearest", RND_NEAREST, 40'h08000, 1'b1, 40'h40000, 40'h08000, 40'h20000, 1'b0);
    // held 0.25 stays above the lowered maximum, so the flag is up before disabling
    step("loss", RND_NEAREST, 40'h20000, 1'b0, 40'h04000, 40'h08000, 40'h20000, 1'b1);
    // switching the curve off must drop the flag
    @(posedge clk);
    cfg.curve_en <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    `CHK("off flag", 1'b0, oor)
    end_sim();
  end
endmodule
bind scaling_curve_unit scaling_curve_props scaling_curve_props_inst (.CLK_I(CLK_I), .RESET_I(RESET_I),
  .MEAS_VALID_I(MEAS_VALID_I), .CFG_I(CFG_I), .CURVE_IN_O(CURVE_IN_O), .CURVE_OUT_O(CURVE_OUT_O),
  .OUT_OF_RANGE_O(OUT_OF_RANGE_O), .RESULT_VALID_O(RESULT_VALID_O));
